// *** sfc_pkg.sv ***
// shared constants for the serial flash status / identification command logic
package sfc_pkg;
  // instruction opcodes
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] WRITE_LATCH_SET_CMD = 8'h06;
  localparam logic [7:0] WRITE_LATCH_CLEAR_CMD = 8'h04;
  localparam logic [7:0] STATUS_WRITE_ARM_CMD = 8'h50;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] ID_READ_CMD_A = 8'h90;
  localparam logic [7:0] ID_READ_CMD_B = 8'hab;
  // status register layout
  localparam int SR_W = 8;
  localparam int BUSY_POS = 0;
  localparam int WRITE_ENABLE_LATCH_POS = 1;
  localparam int PROTECT_LEVEL_BIT0_POS = 2;
  localparam int PROTECT_LEVEL_BIT1_POS = 3;
  localparam int AUTO_INCREMENT_PROGRAM_BIT_POS = 6;
  localparam int PROTECT_LOCKDOWN_BIT_POS = 7;
  localparam logic [SR_W-1:0] SR_RESET = 8'h00;
  // index of the last identification address byte (three address bytes)
  localparam logic [1:0] ID_ADDR_LAST = 2'd2;
  // host link timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCK_HALF_NS = 64;
  localparam int CS_HIGH_NS = 100;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;
  // device command decoder states
  typedef enum logic [2:0] {
    SFC_CMD = 3'b000,
    SFC_ADDR = 3'b001,
    SFC_DATA = 3'b010,
    SFC_DONE = 3'b011,
    SFC_STATUS_OUT = 3'b100,
    SFC_ID_OUT = 3'b101,
    SFC_IGNORE = 3'b110
  } sfc_dev_state_e;
  // host sequencer states
  typedef enum logic [2:0] {
    SFC_H_IDLE = 3'b000,
    SFC_H_SETUP = 3'b001,
    SFC_H_LOW = 3'b010,
    SFC_H_HIGH = 3'b011,
    SFC_H_HOLD = 3'b100,
    SFC_H_GAP = 3'b101
  } sfc_host_state_e;
endpackage

// *** sfc_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// serial link between host and flash; data out is pulled high when undriven
interface sfc_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic wp_n;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // resolved level of the shared data-out wire
  assign miso = miso_oe ? miso_o : 1'b1;
  modport dev(input cs_n, input sck, input mosi, input wp_n, output miso_o, output miso_oe);
  modport host(output cs_n, output sck, output mosi, output wp_n, input miso);
endinterface
`default_nettype wire

// *** sfc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// three-stage pin synchroniser; a change counts once stages two and three agree
module sfc_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic d,
  output logic lvl,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  wire agree = (s2_r == s3_r);

  // stage one is read only by stage two
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      lvl_r <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        lvl_r <= s3_r;
      end
    end
  end

  // edge pulses are one cycle, in the cycle before lvl changes
  assign lvl = lvl_r;
  assign rise = agree & s3_r & ~lvl_r;
  assign fall = agree & ~s3_r & lvl_r;
endmodule
`default_nettype wire

// *** sfc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// serial host: frames one instruction per request (arm then write for a status write), mode 0, clock from a divider
module sfc_host (
  input wire logic clk,
  input wire logic reset_n,
  sfc_link_if.host link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_op,
  input wire logic [23:0] cmd_arg,
  input wire logic [1:0] cmd_arg_bytes,
  input wire logic [7:0] cmd_rd_bytes,
  input wire logic wp_level,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done
);
  import sfc_pkg::*;

  localparam logic [TMR_W-1:0] HALF_LOAD = TMR_W'(SCK_HALF_CYC - 1);
  localparam logic [TMR_W-1:0] GAP_LOAD = TMR_W'(CS_HIGH_CYC - 1);

  sfc_host_state_e state_r;
  logic [TMR_W-1:0] tmr_r;
  logic [31:0] tx_sh_r;
  logic [11:0] bits_r;
  logic [11:0] rd_bits_r;
  logic [7:0] rx_sh_r;
  logic [7:0] op_r;
  logic [23:0] arg_r;
  logic [1:0] n_r;
  logic [7:0] rd_r;
  logic arm_pend_r;
  logic pend_r;
  logic cs_n_r;
  logic sck_r;
  logic mosi_r;
  logic wp_r;
  logic [7:0] rd_data_r;
  logic rd_valid_r;
  logic done_r;
  logic miso_lvl;

  // data-out pin comes from the device's side, so it is synchronised
  sfc_sync #(.INIT(1'b1)) u_miso (
    .clk(clk),
    .reset_n(reset_n),
    .d(link.miso),
    .lvl(miso_lvl),
    .rise(),
    .fall()
  );

  // frame builder: address forced to its lowest bit for identification
  wire is_id = (cmd_op == ID_READ_CMD_A) || (cmd_op == ID_READ_CMD_B);
  wire [23:0] arg_fix = is_id ? {23'h000000, cmd_arg[0]} : cmd_arg; // see RULE21
  wire is_swr = (cmd_op == STATUS_WRITE_CMD);
  wire start = cmd_valid && (state_r == SFC_H_IDLE);
  wire tick = (tmr_r == '0);
  wire [4:0] sh_amt = {2'd3 - n_r, 3'b000};
  wire [31:0] frame = {op_r, arg_r << sh_amt};
  wire [11:0] frame_bits = {5'h00, ({2'b00, n_r} + 4'd1), 3'b000} + {1'b0, rd_r, 3'b000};
  wire rx_byte_end = (bits_r[2:0] == 3'd1) && (bits_r <= rd_bits_r);

  assign cmd_ready = (state_r == SFC_H_IDLE);

  // a status write is always preceded by one arm frame; op_r switches to the write as that arm frame opens
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_r <= '0;
      arg_r <= '0;
      n_r <= '0;
      rd_r <= '0;
      arm_pend_r <= 1'b0;
    end else if (start) begin
      op_r <= is_swr ? STATUS_WRITE_ARM_CMD : cmd_op; // see RULE12
      arg_r <= arg_fix;
      n_r <= is_swr ? 2'd0 : cmd_arg_bytes;
      rd_r <= is_swr ? 8'h00 : cmd_rd_bytes;
      arm_pend_r <= is_swr;
    end else if (state_r == SFC_H_GAP && tick && arm_pend_r) begin
      op_r <= STATUS_WRITE_CMD;
      n_r <= 2'd1;
      arm_pend_r <= 1'b0;
    end
  end

  // link sequencer: chip select framing, clock phases, shifting
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SFC_H_IDLE;
      tmr_r <= '0;
      tx_sh_r <= '0;
      pend_r <= 1'b0;
      bits_r <= '0;
      rd_bits_r <= '0;
      rx_sh_r <= '0;
      cs_n_r <= 1'b1;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      wp_r <= 1'b1;
      rd_data_r <= '0;
      rd_valid_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      rd_valid_r <= 1'b0;
      done_r <= 1'b0;
      wp_r <= wp_level;
      if (!tick) begin
        tmr_r <= tmr_r - 1'b1;
      end
      case (state_r)
        SFC_H_IDLE: begin
          if (start) begin
            state_r <= SFC_H_GAP; // gap timer set to zero, so the frame opens on the next cycle
            pend_r <= 1'b1;
            tmr_r <= '0;
          end
        end
        SFC_H_SETUP: begin
          if (tick) begin
            state_r <= SFC_H_LOW;
            tmr_r <= HALF_LOAD;
          end
        end
        SFC_H_LOW: begin
          if (tick) begin
            sck_r <= 1'b1;
            rx_sh_r <= {rx_sh_r[6:0], miso_lvl};
            if (rx_byte_end) begin
              rd_data_r <= {rx_sh_r[6:0], miso_lvl};
              rd_valid_r <= 1'b1;
            end
            bits_r <= bits_r - 1'b1;
            state_r <= SFC_H_HIGH;
            tmr_r <= HALF_LOAD;
          end
        end
        SFC_H_HIGH: begin
          if (tick) begin
            sck_r <= 1'b0;
            tx_sh_r <= {tx_sh_r[30:0], 1'b0};
            mosi_r <= tx_sh_r[30];
            state_r <= (bits_r == '0) ? SFC_H_HOLD : SFC_H_LOW;
            tmr_r <= HALF_LOAD;
          end
        end
        SFC_H_HOLD: begin
          if (tick) begin
            cs_n_r <= 1'b1; // see RULE4
            state_r <= SFC_H_GAP;
            tmr_r <= GAP_LOAD;
          end
        end
        SFC_H_GAP: begin
          if (tick && !done_r) begin
            // a flag, not the drained shifter, tells a frame still owed from one already sent
            if (pend_r) begin
              pend_r <= arm_pend_r; // frame opened with the arm flag set owes another: arm, then write
              cs_n_r <= 1'b0; // see RULE10
              tx_sh_r <= frame;
              mosi_r <= frame[31];
              bits_r <= frame_bits;
              rd_bits_r <= {1'b0, rd_r, 3'b000};
              state_r <= SFC_H_SETUP;
              tmr_r <= HALF_LOAD;
            end else begin
              done_r <= 1'b1; // see RULE17
              tx_sh_r <= '0;
              state_r <= SFC_H_IDLE;
            end
          end
        end
        default: begin
          state_r <= SFC_H_IDLE;
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sck = sck_r;
  assign link.mosi = mosi_r;
  assign link.wp_n = wp_r;
  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign done = done_r;
endmodule
`default_nettype wire

// *** sfc_device.sv ***
// Behaviour
// RULE1 - status read answered anytime, even while busy
// RULE2 - host polls busy before new instructions; sfc_host does not poll, it sends each request as given
// RULE3 - status streams out until chip select rises
// RULE4 - host holds select low through status read
// RULE5 - latch set instruction sets write enable latch
// RULE6 - host sets latch before each program/erase; sfc_host sends a latch set only when one is requested
// RULE7 - latch set acts on chip select rise
// RULE8 - latch clear zeroes latch and increment bit
// RULE9 - arm holds only for the next instruction
// RULE10 - host frames arm instruction with select
// RULE11 - status write changes protect and lockdown only
// RULE12 - host sends status write right after arm
// RULE13 - write ignored when pin low, lockdown set
// RULE14 - pin low: lockdown only goes zero to one
// RULE15 - pin high: all protect bits freely writable
// RULE16 - pin and lockdown judged at select rise
// RULE17 - host frames status write with select
// RULE18 - two identification opcodes, each with address
// RULE19 - address zero maker code, one part code
// RULE20 - identification bytes alternate until select rises
// RULE21 - host zeroes all address bits but lowest
// RULE22 - output msb first, byte repeats every eight
`timescale 1ns/1ps
`default_nettype none
module sfc_device #(
  parameter logic [7:0] MAKER_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'hc3 // arbitrary value
) (
  input wire logic clk,
  input wire logic reset_n,
  sfc_link_if.dev link,
  input wire logic busy,
  input wire logic incr_set,
  output logic [sfc_pkg::SR_W-1:0] status
);
  import sfc_pkg::*;

  // identification byte for a given address bit
  function automatic logic [7:0] id_code(input logic sel);
    id_code = sel ? PART_CODE : MAKER_CODE; // see RULE19
  endfunction

  logic cs_lvl;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  logic mosi_lvl;
  logic wp_lvl;

  // all link pins arrive from the host's side and are synchronised
  sfc_sync #(.INIT(1'b1)) u_cs (
    .clk(clk),
    .reset_n(reset_n),
    .d(link.cs_n),
    .lvl(cs_lvl),
    .rise(cs_rise),
    .fall()
  );
  sfc_sync #(.INIT(1'b0)) u_sck (
    .clk(clk),
    .reset_n(reset_n),
    .d(link.sck),
    .lvl(),
    .rise(sck_rise),
    .fall(sck_fall)
  );
  sfc_sync #(.INIT(1'b0)) u_mosi (
    .clk(clk),
    .reset_n(reset_n),
    .d(link.mosi),
    .lvl(mosi_lvl),
    .rise(),
    .fall()
  );
  sfc_sync #(.INIT(1'b1)) u_wp (
    .clk(clk),
    .reset_n(reset_n),
    .d(link.wp_n),
    .lvl(wp_lvl),
    .rise(),
    .fall()
  );

  sfc_dev_state_e state_r;
  logic [6:0] rx_sh_r;
  logic [2:0] bit_cnt_r;
  logic [1:0] byte_cnt_r;
  logic [7:0] cmd_r;
  logic [7:0] data_r;
  logic [7:0] tx_sh_r;
  logic [2:0] tx_cnt_r;
  logic id_sel_r;
  logic miso_r;
  logic oe_r;
  logic latch_r;
  logic incr_r;
  logic [1:0] level_r;
  logic lockdown_r;
  logic armed_r;
  logic [SR_W-1:0] status_r;
  logic [SR_W-1:0] sr_live;

  // live status image; busy comes straight from the array engine
  always_comb begin
    sr_live = SR_RESET;
    sr_live[BUSY_POS] = busy; // see RULE1
    sr_live[WRITE_ENABLE_LATCH_POS] = latch_r;
    sr_live[PROTECT_LEVEL_BIT0_POS] = level_r[0];
    sr_live[PROTECT_LEVEL_BIT1_POS] = level_r[1];
    sr_live[AUTO_INCREMENT_PROGRAM_BIT_POS] = incr_r;
    sr_live[PROTECT_LOCKDOWN_BIT_POS] = lockdown_r;
  end

  // byte assembly and decode of the byte just completed
  wire sel = ~cs_lvl;
  wire [7:0] rx_byte = {rx_sh_r, mosi_lvl};
  wire byte_done = sel && sck_rise && (bit_cnt_r == 3'd7);
  wire is_id = (rx_byte == ID_READ_CMD_A) || (rx_byte == ID_READ_CMD_B);
  wire is_simple = (rx_byte == WRITE_LATCH_SET_CMD) || (rx_byte == WRITE_LATCH_CLEAR_CMD)
    || (rx_byte == STATUS_WRITE_ARM_CMD);
  wire out_state = (state_r == SFC_STATUS_OUT) || (state_r == SFC_ID_OUT);
  wire shift_out = sel && sck_fall && out_state;

  // instructions execute only if the frame ended on a whole byte boundary
  wire done_ok = cs_rise && (state_r == SFC_DONE) && (bit_cnt_r == 3'd0);
  wire do_set = done_ok && (cmd_r == WRITE_LATCH_SET_CMD); // see RULE7
  wire do_clear = done_ok && (cmd_r == WRITE_LATCH_CLEAR_CMD);
  wire do_arm = done_ok && (cmd_r == STATUS_WRITE_ARM_CMD);
  // pin level and lockdown as they stand in the cycle select rises
  wire wr_allowed = wp_lvl || !lockdown_r; // see RULE13
  wire do_swr = done_ok && (cmd_r == STATUS_WRITE_CMD) && armed_r && wr_allowed; // see RULE16

  // command decoder
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SFC_CMD;
      rx_sh_r <= '0;
      bit_cnt_r <= '0;
      byte_cnt_r <= '0;
      cmd_r <= '0;
      data_r <= '0;
    end else if (!sel) begin
      state_r <= SFC_CMD;
      bit_cnt_r <= '0;
      byte_cnt_r <= '0;
    end else if (sck_rise) begin
      rx_sh_r <= rx_byte[6:0];
      bit_cnt_r <= bit_cnt_r + 3'd1;
      if (byte_done) begin
        case (state_r)
          SFC_CMD: begin
            cmd_r <= rx_byte;
            if (rx_byte == STATUS_READ_CMD) begin
              state_r <= SFC_STATUS_OUT;
            end else if (is_id) begin
              state_r <= SFC_ADDR; // see RULE18
            end else if (rx_byte == STATUS_WRITE_CMD) begin
              state_r <= SFC_DATA;
            end else if (is_simple) begin
              state_r <= SFC_DONE;
            end else begin
              state_r <= SFC_IGNORE; // array instructions are handled elsewhere
            end
          end
          SFC_ADDR: begin
            byte_cnt_r <= byte_cnt_r + 2'd1;
            if (byte_cnt_r == ID_ADDR_LAST) begin
              state_r <= SFC_ID_OUT;
            end
          end
          SFC_DATA: begin
            data_r <= rx_byte;
            state_r <= SFC_DONE;
          end
          SFC_DONE: begin
            state_r <= SFC_IGNORE; // trailing bytes void the instruction
          end
          default: begin
            state_r <= state_r;
          end
        endcase
      end
    end
  end

  // output shifter: loaded when a read instruction completes, shifts on falling clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_sh_r <= '0;
      tx_cnt_r <= '0;
      id_sel_r <= 1'b0;
      miso_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      oe_r <= sel && out_state;
      if (byte_done && state_r == SFC_CMD) begin
        tx_sh_r <= sr_live; // see RULE1
        tx_cnt_r <= '0;
      end else if (byte_done && state_r == SFC_ADDR && byte_cnt_r == ID_ADDR_LAST) begin
        id_sel_r <= mosi_lvl;
        tx_sh_r <= id_code(mosi_lvl); // see RULE19
        tx_cnt_r <= '0;
      end else if (shift_out) begin
        miso_r <= tx_sh_r[7]; // see RULE22
        tx_cnt_r <= tx_cnt_r + 3'd1;
        if (tx_cnt_r != 3'd7) begin
          tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end else if (state_r == SFC_STATUS_OUT) begin
          tx_sh_r <= sr_live; // see RULE3
        end else begin
          id_sel_r <= ~id_sel_r;
          tx_sh_r <= id_code(~id_sel_r); // see RULE20
        end
      end
    end
  end

  // status bits; a hardware set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_r <= SR_RESET[WRITE_ENABLE_LATCH_POS];
      incr_r <= SR_RESET[AUTO_INCREMENT_PROGRAM_BIT_POS];
      level_r <= {SR_RESET[PROTECT_LEVEL_BIT1_POS], SR_RESET[PROTECT_LEVEL_BIT0_POS]};
      lockdown_r <= SR_RESET[PROTECT_LOCKDOWN_BIT_POS];
      armed_r <= 1'b0;
      status_r <= SR_RESET;
    end else begin
      status_r <= sr_live;
      if (do_set) begin
        latch_r <= 1'b1; // see RULE5
      end else if (do_clear) begin
        latch_r <= 1'b0; // see RULE8
      end
      if (incr_set) begin
        incr_r <= 1'b1;
      end else if (do_clear) begin
        incr_r <= 1'b0; // see RULE8
      end
      if (cs_rise) begin
        armed_r <= do_arm; // see RULE9
      end
      if (do_swr) begin
        // pin high frees all three; pin low reaches here only with lockdown clear
        level_r <= {data_r[PROTECT_LEVEL_BIT1_POS], data_r[PROTECT_LEVEL_BIT0_POS]}; // see RULE11
        lockdown_r <= data_r[PROTECT_LOCKDOWN_BIT_POS]; // see RULE14 see RULE15
      end
    end
  end

  assign link.miso_o = miso_r;
  assign link.miso_oe = oe_r;
  assign status = status_r;
endmodule
`default_nettype wire

// *** sfc_host_note_unused.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** sfc_link_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches the host/flash link wires from beside the interface
module sfc_link_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic wp_n,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  // one clock domain, so clock and reset are given once here
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // host framing of every instruction
  sck_framed_a: assert property ($rose(sck) |-> !cs_n)
    else $error("serial clock rose while deselected");
  cs_setup_a: assert property ($fell(cs_n) |-> !sck [*8])
    else $error("clock moved too soon after select fell");
  cs_rise_a: assert property ($rose(cs_n) |-> !sck && !$past(sck, 4))
    else $error("select rose without clock settled low");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock not idle while deselected");
  cs_gap_a: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("select high gap too short");
  // one bit per serial clock, data steady around the sampling edge
  sck_width_a: assert property ($rose(sck) |-> sck [*8])
    else $error("serial clock high phase too short");
  mosi_stable_a: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("host data moved while clock high");
  miso_stable_a: assert property (sck && $past(sck) && $past(miso_oe) |-> $stable(miso_o))
    else $error("device data moved while clock high");
  // the device only drives inside a frame and lets go soon after it ends
  oe_release_a: assert property ($rose(cs_n) |-> ##[1:8] !miso_oe)
    else $error("device kept driving after select rose");
  oe_select_a: assert property ($rose(miso_oe) |-> !cs_n && !$past(cs_n, 4))
    else $error("device started driving outside a frame");
  // a released data-out wire rests at its pull-up level between frames
  miso_idle_a: assert property (cs_n && $past(cs_n, 8) |-> miso)
    else $error("data out not released between frames");
  // the pin level judged at select rise must not move inside a frame
  wp_steady_a: assert property (!cs_n |-> $stable(wp_n))
    else $error("write-protect pin moved inside a frame");
endmodule
`default_nettype wire

// *** spi_flash_status_id_commands_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) err(nm, e, g); end
module spi_flash_status_id_commands_bench;
  import sfc_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // arbitrary value
  localparam logic [7:0] PART = 8'h3c; // arbitrary value
  localparam int LK = PROTECT_LOCKDOWN_BIT_POS;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic cmd_valid = 1'h0;
  logic cmd_ready;
  logic [7:0] cmd_op = 8'h00;
  logic [23:0] cmd_arg = 24'h000000;
  logic [1:0] cmd_arg_bytes = 2'h0;
  logic [7:0] cmd_rd_bytes = 8'h00;
  logic wp_level = 1'h1;
  logic busy = 1'h0;
  logic incr_set = 1'h0;
  logic [7:0] rd_data;
  logic rd_valid;
  logic done;
  logic [7:0] status;
  logic [7:0] exp_sr = 8'h00;
  logic [7:0] rx [8];
  int mismatches = 0;
  int n_checks = 0;
  sfc_link_if link ();
  sfc_host sfc_host_inst (.clk(clk), .reset_n(reset_n), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_arg(cmd_arg), .cmd_arg_bytes(cmd_arg_bytes),
    .cmd_rd_bytes(cmd_rd_bytes), .wp_level(wp_level), .rd_data(rd_data),
    .rd_valid(rd_valid), .done(done));
  sfc_device #(.MAKER_CODE(MAKER), .PART_CODE(PART)) sfc_device_inst (.clk(clk),
    .reset_n(reset_n), .link(link), .busy(busy), .incr_set(incr_set), .status(status));
  sfc_link_checker sfc_link_checker_inst (.clk(clk), .reset_n(reset_n), .cs_n(link.cs_n),
    .sck(link.sck), .mosi(link.mosi), .wp_n(link.wp_n), .miso_o(link.miso_o),
    .miso_oe(link.miso_oe), .miso(link.miso));
  // 200 MHz system clock
  always #2.5 clk = ~clk;
  task automatic err(input string nm, input logic [7:0] e, input logic [7:0] g);
    mismatches++;
    $display("[ERR] %s expected %h seen %h", nm, e, g);
  endtask
  // one host request; read bytes land in rx, bounded wait for done
  task automatic run(input logic [7:0] op, input logic [23:0] arg, input logic [1:0] nb,
      input logic [7:0] rb);
    int n;
    int k;
    k = 0;
    @(negedge clk);
    cmd_op = op;
    cmd_arg = arg;
    cmd_arg_bytes = nb;
    cmd_rd_bytes = rb;
    cmd_valid = 1'h1;
    @(negedge clk);
    cmd_valid = 1'h0;
    for (n = 0; n < 4000 && done !== 1'h1; n++) begin
      @(negedge clk);
      if (rd_valid === 1'h1) begin
        rx[k[2:0]] = rd_data;
        k++;
      end
    end
    `CHK("done seen", 1'h1, done)
    `CHK("read count", rb, k[7:0])
  endtask
  // two status bytes in one frame, plus the status image port
  task automatic read_sr(input string nm);
    logic [7:0] e;
    e = {exp_sr[7:1], busy};
    run(STATUS_READ_CMD, 24'h000000, 2'h0, 8'h02);
    `CHK(nm, e, rx[0])
    `CHK(nm, e, rx[1])
    `CHK(nm, e, status)
  endtask
  // expected protect bits follow the pin and lockdown state at the write
  task automatic wsr(input logic wp, input logic [7:0] d);
    wp_level = wp;
    run(STATUS_WRITE_CMD, {16'h0000, d}, 2'h1, 8'h00);
    if (wp || !exp_sr[LK]) begin
      exp_sr[LK] = d[LK];
      exp_sr[PROTECT_LEVEL_BIT1_POS] = d[PROTECT_LEVEL_BIT1_POS];
      exp_sr[PROTECT_LEVEL_BIT0_POS] = d[PROTECT_LEVEL_BIT0_POS];
    end
    read_sr("protect bits");
  endtask
  task automatic t_busy;
    busy = 1'h1;
    read_sr("busy status");
    busy = 1'h0;
    read_sr("idle status");
    $display("test busy done");
  endtask
  task automatic t_latch;
    run(WRITE_LATCH_SET_CMD, 24'h000000, 2'h0, 8'h00);
    exp_sr[WRITE_ENABLE_LATCH_POS] = 1'h1;
    read_sr("latch set");
    $display("test latch done");
  endtask
  // a clear must drop both the latch and the increment bit
  task automatic t_clear;
    @(negedge clk);
    incr_set = 1'h1;
    @(negedge clk);
    incr_set = 1'h0;
    exp_sr[AUTO_INCREMENT_PROGRAM_BIT_POS] = 1'h1;
    read_sr("increment set");
    run(WRITE_LATCH_CLEAR_CMD, 24'h000000, 2'h0, 8'h00);
    exp_sr[AUTO_INCREMENT_PROGRAM_BIT_POS] = 1'h0;
    exp_sr[WRITE_ENABLE_LATCH_POS] = 1'h0;
    read_sr("latch clear");
    $display("test clear done");
  endtask
  task automatic t_protect;
    wsr(1'h1, 8'hff);
    wsr(1'h0, 8'h00);
    wsr(1'h1, 8'h00);
    wsr(1'h0, 8'h84);
    wsr(1'h0, 8'h04);
    wsr(1'h1, 8'h00);
    $display("test protect done");
  endtask
  // both opcodes, both start addresses, codes alternate per byte
  task automatic t_ident;
    run(ID_READ_CMD_A, 24'h000000, 2'h3, 8'h04);
    for (int i = 0; i < 4; i++) begin
      `CHK("ident a", i[0] ? PART : MAKER, rx[i])
    end
    run(ID_READ_CMD_B, 24'h000001, 2'h3, 8'h03);
    for (int i = 0; i < 3; i++) begin
      `CHK("ident b", i[0] ? MAKER : PART, rx[i])
    end
    $display("test ident done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset_n = 1'h1;
    t_busy();
    t_latch();
    t_clear();
    t_protect();
    t_ident();
    end_sim();
  end
  // hang guard: about 60k cycles, nearly four times the roughly 15.5k cycles the tests need
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
